// File: bsc_pkg.sv
// Package: register map, field layout, defaults and timing for system control two
// Functional notes
// - Deglitch field codes 00..11 select under 1us, 6us, 12us, 30us power-good delay.
// - Power-good output changes only after fault state holds for the selected delay.
// - Frequency field codes select 500 kHz, 750 kHz, 1 MHz, 1.25 MHz.
// - No oscillator; on-time timer length is set from the frequency field.
// - Soft-stop clear: after enable shutdown the output is left uncontrolled.
// - Soft-stop set: output target ramps linearly to zero after enable shutdown.
// - Current-limit field codes select valley limits 16,14,12,10,8.5,7,6,5 A.
// - One current-limit field drives both peak and valley thresholds.
// - Reset defaults: deglitch 11, frequency 00, soft-stop 0, current limit 001.
// - Enable pin low turns converter off and blocks register writes; reads still return the register.
package bsc_pkg;
  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] REG_SYS_CTRL_TWO = 8'h02;
  localparam int DEGLITCH_HI = 7;
  localparam int DEGLITCH_LO = 6;
  localparam int FREQ_HI = 5;
  localparam int FREQ_LO = 4;
  localparam int SOFT_STOP_BIT = 3;
  localparam int ILIM_HI = 2;
  localparam int ILIM_LO = 0;

  typedef struct packed {
    logic [1:0] deglitch;
    logic [1:0] freq;
    logic soft_stop;
    logic [2:0] ilim;
  } bsc_ctrl_t;

  localparam bsc_ctrl_t CTRL_RESET = '{deglitch: 2'h3, freq: 2'h0, soft_stop: 1'h0, ilim: 3'h1};

  // ----------------------------------------
  // Timing, clock at 250 MHz
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int DG0_NS = 996;
  localparam int DG1_US = 6;
  localparam int DG2_US = 12;
  localparam int DG3_US = 30;
  // Longest time for code 00 rounds down, others are the printed delays
  localparam int DG0_CYC = DG0_NS * CLK_MHZ / 1000;
  localparam int DG1_CYC = DG1_US * CLK_MHZ;
  localparam int DG2_CYC = DG2_US * CLK_MHZ;
  localparam int DG3_CYC = DG3_US * CLK_MHZ;
  localparam int CNT_W = 13;

  // On-time scaled from switching period; one cycle per period per unit duty
  localparam int F0_KHZ = 500;
  localparam int F1_KHZ = 750;
  localparam int F2_KHZ = 1000;
  localparam int F3_KHZ = 1250;
  localparam int TON_W = 10;

  // Valley limits in tenths of an amp, peak offset above valley
  localparam int ILIM_W = 8;
  localparam logic [7:0] PEAK_OFFSET = 8'h1E;
  localparam int STOP_W = 16;
  // Soft-stop step length as a power of two, one reference step per wrap
  localparam int STEP_W = 8;
  localparam logic [7:0] VREF_FULL = 8'hFF;

  typedef struct packed {
    logic [ILIM_W-1:0] valley;
    logic [ILIM_W-1:0] peak;
  } bsc_ilim_t;
endpackage

// File: bsc_deglitch.sv
// Power-good deglitch filter with selectable delay
`timescale 1ns/1ps
module bsc_deglitch (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic [1:0] sel,
  input wire logic fault,
  // Result
  output logic pg
);
  logic [bsc_pkg::CNT_W-1:0] count;

  function automatic logic [bsc_pkg::CNT_W-1:0] delay_of(input logic [1:0] code);
    case (code)
      2'h0: delay_of = bsc_pkg::CNT_W'(bsc_pkg::DG0_CYC);
      2'h1: delay_of = bsc_pkg::CNT_W'(bsc_pkg::DG1_CYC);
      2'h2: delay_of = bsc_pkg::CNT_W'(bsc_pkg::DG2_CYC);
      default: delay_of = bsc_pkg::CNT_W'(bsc_pkg::DG3_CYC);
    endcase
  endfunction

  // Any return to agreement restarts the count, so short glitches never reach the pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (fault != pg) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // Note pg is active high meaning "good", so fault==pg means mismatch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pg <= 1'b0;
    end else if (fault == pg && count + 1'b1 >= delay_of(sel)) begin
      pg <= ~fault;
    end
  end

  chk_pg_waits_delay: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(pg) |-> $past(count) + 1'b1 >= delay_of($past(sel))) else $error("pg changed early");
endmodule

// File: bsc_sys_ctrl_two.sv
// System control register two and the converter controls it steers
`timescale 1ns/1ps
module bsc_sys_ctrl_two (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Enable pin and internal enable bit
  input wire logic enable_pin,
  input wire logic enable_bit,
  // Register port from the serial interface block
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Fault comparators
  input wire logic overvoltage_fault,
  input wire logic undervoltage_fault,
  // Converter controls
  output logic power_good_output,
  output logic [bsc_pkg::TON_W-1:0] on_time_cycles,
  output bsc_pkg::bsc_ilim_t ilim,
  output logic conv_on,
  output logic discharge_active,
  output logic output_hold,
  output logic [7:0] ref_target
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] en_sync;
  logic [1:0] ov_sync;
  logic [1:0] uv_sync;
  // Two flops keep a slow or metastable pin away from the write gate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_sync <= '0;
      ov_sync <= '0;
      uv_sync <= '0;
    end else begin
      en_sync <= {en_sync[0], enable_pin};
      ov_sync <= {ov_sync[0], overvoltage_fault};
      uv_sync <= {uv_sync[0], undervoltage_fault};
    end
  end
  logic pin_en;
  assign pin_en = en_sync[1];

  // ----------------------------------------
  // Register
  // ----------------------------------------
  bsc_pkg::bsc_ctrl_t ctrl;
  logic hit;
  assign hit = reg_wr && pin_en && reg_addr == bsc_pkg::REG_SYS_CTRL_TWO;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= bsc_pkg::CTRL_RESET;
    end else if (hit) begin
      ctrl.deglitch <= reg_wdata[bsc_pkg::DEGLITCH_HI:bsc_pkg::DEGLITCH_LO];
      ctrl.freq <= reg_wdata[bsc_pkg::FREQ_HI:bsc_pkg::FREQ_LO];
      ctrl.soft_stop <= reg_wdata[bsc_pkg::SOFT_STOP_BIT];
      ctrl.ilim <= reg_wdata[bsc_pkg::ILIM_HI:bsc_pkg::ILIM_LO];
    end
  end

  // Other addresses read as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == bsc_pkg::REG_SYS_CTRL_TWO) begin
      reg_rdata <= ctrl;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Power good
  // ----------------------------------------
  bsc_deglitch u_deglitch (
    .clk(clk),
    .sys_rst(sys_rst),
    .sel(ctrl.deglitch),
    .fault(ov_sync[1] | uv_sync[1]),
    .pg(power_good_output)
  );

  // ----------------------------------------
  // On-time from frequency
  // ----------------------------------------
  function automatic logic [bsc_pkg::TON_W-1:0] ton_of(input logic [1:0] code);
    int khz;
    case (code)
      2'h0: khz = bsc_pkg::F0_KHZ;
      2'h1: khz = bsc_pkg::F1_KHZ;
      2'h2: khz = bsc_pkg::F2_KHZ;
      default: khz = bsc_pkg::F3_KHZ;
    endcase
    // One switching period in clock cycles; loop scales by duty elsewhere
    ton_of = bsc_pkg::TON_W'(bsc_pkg::CLK_MHZ * 1000 / khz);
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      on_time_cycles <= ton_of(bsc_pkg::CTRL_RESET.freq);
    end else begin
      on_time_cycles <= ton_of(ctrl.freq);
    end
  end

  // ----------------------------------------
  // Current limit, one field for both thresholds
  // ----------------------------------------
  function automatic logic [bsc_pkg::ILIM_W-1:0] valley_of(input logic [2:0] code);
    case (code)
      3'h0: valley_of = 8'hA0;
      3'h1: valley_of = 8'h8C;
      3'h2: valley_of = 8'h78;
      3'h3: valley_of = 8'h64;
      3'h4: valley_of = 8'h55;
      3'h5: valley_of = 8'h46;
      3'h6: valley_of = 8'h3C;
      default: valley_of = 8'h32;
    endcase
  endfunction

  // Peak comes from the same code, so the two limits cannot drift apart
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ilim.valley <= valley_of(bsc_pkg::CTRL_RESET.ilim);
      ilim.peak <= valley_of(bsc_pkg::CTRL_RESET.ilim) + bsc_pkg::PEAK_OFFSET;
    end else begin
      ilim.valley <= valley_of(ctrl.ilim);
      ilim.peak <= valley_of(ctrl.ilim) + bsc_pkg::PEAK_OFFSET;
    end
  end

  // ----------------------------------------
  // Enable and soft stop
  // ----------------------------------------
  logic on_req;
  // Wraps once per step; a power of two keeps the step test to an AND
  logic [bsc_pkg::STEP_W-1:0] stop_cnt;
  assign on_req = pin_en & enable_bit;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_on <= 1'b0;
    end else begin
      conv_on <= on_req;
    end
  end

  // Ramp down one step per slow tick for a linear discharge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_target <= 8'h00;
      discharge_active <= 1'b0;
      stop_cnt <= '0;
    end else if (on_req) begin
      ref_target <= bsc_pkg::VREF_FULL;
      discharge_active <= 1'b0;
      stop_cnt <= '0;
    end else if (conv_on && ctrl.soft_stop) begin
      discharge_active <= 1'b1;
    end else if (discharge_active) begin
      stop_cnt <= stop_cnt + 1'b1;
      if (&stop_cnt) begin
        if (ref_target == 8'h00) begin
          discharge_active <= 1'b0;
        end else begin
          ref_target <= ref_target - 1'b1;
        end
      end
    end
  end

  // Soft-stop clear: output left floating, no discharge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_hold <= 1'b0;
    end else begin
      output_hold <= ~on_req & ~discharge_active & ~(conv_on & ctrl.soft_stop);
    end
  end

  chk_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
    hit |=> ctrl == $past(reg_wdata)) else $error("write not stored");
  chk_pin_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && !pin_en) |=> $stable(ctrl)) else $error("write with pin low");
  chk_peak_tracks: assert property (@(posedge clk) disable iff (sys_rst)
    ilim.peak == ilim.valley + bsc_pkg::PEAK_OFFSET) else $error("peak apart from valley");
  chk_valley_code: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 ctrl.ilim == 3'h0 && $stable(ctrl.ilim) |-> ilim.valley == 8'hA0) else $error("valley wrong");
  chk_ton_500k: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl.freq == 2'h0) ##1 (ctrl.freq == 2'h0) |-> on_time_cycles == 10'h1F4) else $error("ton wrong");
  chk_no_discharge: assert property (@(posedge clk) disable iff (sys_rst)
    (!ctrl.soft_stop && !discharge_active && !on_req) |=> !discharge_active) else $error("discharge");
  chk_ramp_down: assert property (@(posedge clk) disable iff (sys_rst)
    discharge_active && !on_req |=> ref_target <= $past(ref_target)) else $error("ramp rose");
  chk_off_pin: assert property (@(posedge clk) disable iff (sys_rst)
    !pin_en |=> !conv_on) else $error("on with pin low");

  // ----------------------------------------
  // Soft stop, readback and on-time checks
  // ----------------------------------------
  sequence seq_stop_start;
    conv_on && ctrl.soft_stop && !on_req;
  endsequence
  sequence seq_stop_idle;
    !on_req && !conv_on && !discharge_active;
  endsequence
  chk_stop_starts: assert property (@(posedge clk) disable iff (sys_rst)
    seq_stop_start |=> discharge_active) else $error("soft stop not started");
  chk_hold_idle: assert property (@(posedge clk) disable iff (sys_rst)
    seq_stop_idle |=> output_hold) else $error("output not released");
  chk_ref_full: assert property (@(posedge clk) disable iff (sys_rst)
    on_req |=> ref_target == bsc_pkg::VREF_FULL) else $error("ref not full when on");
  chk_rdata_mirror: assert property (@(posedge clk) disable iff (sys_rst)
    reg_addr == bsc_pkg::REG_SYS_CTRL_TWO |=> reg_rdata == $past(ctrl)) else $error("readback wrong");
  chk_ton_750k: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl.freq == 2'h1) ##1 (ctrl.freq == 2'h1) |-> on_time_cycles == 10'h14D) else $error("ton 750k wrong");
  chk_ton_1m: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl.freq == 2'h2) ##1 (ctrl.freq == 2'h2) |-> on_time_cycles == 10'h0FA) else $error("ton 1m wrong");
endmodule

// File: bsc_host.sv
// Register host model for the register port
`timescale 1ns/1ps
module bsc_host #(
  parameter int GAP = 1
) (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Data not held after the strobe, so show the inverse
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~data;
    repeat (GAP) @(negedge clk);
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    reg_addr = addr;
    repeat (3) @(negedge clk);
    data = reg_rdata;
    repeat (GAP) @(negedge clk);
  endtask
endmodule

// File: bsc_sys_ctrl_two_tb.sv
// Self-checking bench for system control register two
`timescale 1ns/1ps
module bsc_sys_ctrl_two_tb;
  logic clk, sys_rst, enable_pin, enable_bit, ov, uv;
  logic reg_wr, pg, conv_on, dis, hold;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ref_t, rd;
  logic [bsc_pkg::TON_W-1:0] ton;
  bsc_pkg::bsc_ilim_t ilim;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  int valley_tab [8] = '{160, 140, 120, 100, 85, 70, 60, 50};
  int khz_tab [4] = '{500, 750, 1000, 1250};
  int dg_us [4] = '{0, 6, 12, 30};
  bsc_sys_ctrl_two dut (.clk(clk), .sys_rst(sys_rst), .enable_pin(enable_pin), .enable_bit(enable_bit),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .overvoltage_fault(ov), .undervoltage_fault(uv), .power_good_output(pg), .on_time_cycles(ton),
    .ilim(ilim), .conv_on(conv_on), .discharge_active(dis), .output_hold(hold), .ref_target(ref_t));
  bsc_host #(.GAP(1)) host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] cb(int dg, int fr, int ss, int il);
    return {dg[1:0], fr[1:0], ss[0], il[2:0]};
  endfunction
  // Count negedges until pg shows the wanted level, bounded
  task automatic wait_pg(input logic lvl);
    n = 0;
    while (pg !== lvl && n < 9000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 9000) begin
      num_errors++;
    end
  endtask
  // Drive one comparator and count cycles until pg follows
  task automatic measure_pg(input logic f, input logic use_uv, input int code);
    @(negedge clk);
    ov = f & ~use_uv;
    uv = f & use_uv;
    wait_pg(~f);
    check("pg delay", 16'(n >= dg_us[code] * 250 && n <= dg_us[code] * 250 + 252 * (code == 0) + 6), 16'h1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    enable_pin = 1'b1;
    enable_bit = 1'b1;
    ov = 1'b0;
    uv = 1'b0;
    repeat (5) @(negedge clk);
    check("reset pg", 16'(pg), 16'h0);
    sys_rst = 1'b0;
    wait_pg(1'b1);
    check("pg after reset", 16'(n >= dg_us[3] * 250 && n <= dg_us[3] * 250 + 6), 16'h1);
    host.read_reg(8'h02, rd);
    check("reset value", 16'(rd), 16'hC1);
    check("reset on time", 16'(ton), 16'h1F4);
    check("reset valley", 16'(ilim.valley), 16'h8C);
    for (int fr = 0; fr < 4; fr++) begin
      host.write_reg(8'h02, cb(3, fr, 0, 1));
      repeat (3) @(negedge clk);
      check("on time", 16'(ton), 16'(250000 / khz_tab[fr]));
    end
    for (int il = 0; il < 8; il++) begin
      host.write_reg(8'h02, cb(3, 0, 0, il));
      host.read_reg(8'h02, rd);
      check("readback", 16'(rd), 16'(cb(3, 0, 0, il)));
      check("valley", 16'(ilim.valley), 16'(valley_tab[il]));
      check("peak", 16'(ilim.peak), 16'(valley_tab[il] + 30));
    end
    for (int dg = 0; dg < 3; dg++) begin
      host.write_reg(8'h02, cb(dg, 0, 0, 1));
      measure_pg(1'b1, dg[0], dg);
      measure_pg(1'b0, dg[0], dg);
    end
    host.write_reg(8'h02, cb(1, 0, 0, 1));
    ov = 1'b1;
    repeat (1400) @(negedge clk);
    ov = 1'b0;
    repeat (4) @(negedge clk);
    check("glitch ignored", 16'(pg), 16'h1);
    host.write_reg(8'h05, 8'h00);
    host.read_reg(8'h05, rd);
    check("unmapped read", 16'(rd), 16'h0);
    enable_pin = 1'b0;
    repeat (4) @(negedge clk);
    check("pin off", 16'(conv_on), 16'h0);
    host.write_reg(8'h02, 8'h00);
    enable_pin = 1'b1;
    repeat (4) @(negedge clk);
    host.read_reg(8'h02, rd);
    check("write blocked", 16'(rd), 16'h41);
    check("pin on", 16'(conv_on), 16'h1);
    enable_bit = 1'b0;
    repeat (3) @(negedge clk);
    check("no discharge", 16'({hold, dis}), 16'h2);
    enable_bit = 1'b1;
    host.write_reg(8'h02, cb(1, 0, 1, 1));
    check("ref when on", 16'(ref_t), 16'hFF);
    enable_bit = 1'b0;
    repeat (2) @(negedge clk);
    check("discharge on", 16'(dis), 16'h1);
    check("hold in ramp", 16'(hold), 16'h0);
    repeat (520) @(negedge clk);
    check("ramp step", 16'(ref_t >= 8'hFC && ref_t <= 8'hFE), 16'h1);
    n = 0;
    while (dis !== 1'b0 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    check("ramp done", 16'(n < 70000), 16'h1);
    check("ref at zero", 16'(ref_t), 16'h0);
    @(negedge clk);
    check("hold after ramp", 16'(hold), 16'h1);
    print_verdict();
  end
endmodule
